/* rtl/spi_stall_pkg.sv */
// Shared constants, register map and state types of the transmit-stall block.
package spi_stall_pkg;

    // Register byte offsets on the APB side.
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_THRESH = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_XFER = 8'h10;

    // Control register fields.
    localparam int CTRL_STALL_BIT = 5;
    localparam int CTRL_IRQEN_BIT = 4;
    localparam int CTRL_RXREQ_BIT = 3;

    // Interrupt status and mask fields share one layout.
    localparam int INT_DONE_BIT = 0;
    localparam int INT_RXREQ_BIT = 1;

    // Transfer request register field.
    localparam int XFER_GO_BIT = 0;

    // Reset values.
    localparam logic STALL_RESET = 1'b0;
    localparam logic IRQEN_RESET = 1'b1;
    localparam logic MASK_RX_RESET = 1'b0;

    // Serial byte framing.
    localparam logic [7:0] FILLER_BYTE = 8'hFF;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int SCK_HALF_DEFAULT = 4;
    localparam int RX_CNT_W_DEFAULT = 4;

    typedef enum logic {XF_IDLE, XF_SHIFT} xfer_state_type;
    typedef enum logic {SH_IDLE, SH_RUN} shift_state_type;

endpackage : spi_stall_pkg

/* rtl/shift_if.sv */
// Link between the transfer control and the byte shifter.
`timescale 1ns/1ps
interface shift_if;
    logic start;
    logic [7:0] data;
    logic done;
    logic sck;
    logic mosi;

    modport ctl (output start, output data, input done, input sck,
                 input mosi);
    modport eng (input start, input data, output done, output sck,
                 output mosi);
endinterface : shift_if

/* rtl/spi_byte_shifter.sv */
// Byte shifter that sends one byte MSB first with a divided serial clock.
`timescale 1ns/1ps
module spi_byte_shifter
#(
    parameter int HALF_CYCLES = spi_stall_pkg::SCK_HALF_DEFAULT
)
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control side.
    shift_if.eng bus
);
    import spi_stall_pkg::*;

    localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
    localparam logic [CW-1:0] DIV_LAST = CW'(HALF_CYCLES - 1);

    typedef struct packed {
        shift_state_type st;
        logic [CW-1:0] div;
        logic [3:0] falls;
        logic [7:0] sh;
        logic sck;
        logic done;
    } shifter_state_type;

    shifter_state_type s_q;
    shifter_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            SH_IDLE:
            begin
                if (bus.start)
                begin
                    s_d.sh = bus.data;
                    s_d.div = '0;
                    s_d.falls = '0;
                    s_d.sck = 1'b0;
                    s_d.st = SH_RUN;
                end
            end
            SH_RUN:
            begin
                if (s_q.div == DIV_LAST)
                begin
                    s_d.div = '0;
                    s_d.sck = ~s_q.sck;
                    // A falling edge moves to the next bit.
                    if (s_q.sck)
                    begin
                        s_d.falls = s_q.falls + 4'h1;
                        s_d.sh = {s_q.sh[6:0], 1'b1};
                        if (s_q.falls == BYTE_BITS - 4'h1)
                        begin
                            s_d.st = SH_IDLE;
                            s_d.done = 1'b1;
                        end
                    end
                end
                else
                begin
                    s_d.div = s_q.div + CW'(1);
                end
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bus.done = s_q.done;
    assign bus.sck = s_q.sck;
    assign bus.mosi = s_q.sh[7];

endmodule : spi_byte_shifter

/* rtl/spi_fifo_hold_and_request.sv */
// Transmit stall, transfer interrupt and receive request logic with APB.
//
// Overview of operation
// [RULE_01] A stall raised mid-byte lets that byte finish shifting first.
// [RULE_02] While stalled, new transfers send 0xFF and never pop the FIFO.
// [RULE_03] After the stall clears, bytes come from the FIFO in order.
// [RULE_04] Enable at 1 (reset 1, read-write): done flag raises interrupt.
// [RULE_05] Enable at 0: a set done flag raises no interrupt.
// [RULE_06] Request flag is 1 when receive count exceeds the threshold.
// [RULE_07] Request flag is 0 when count is at most threshold; resets 0.
// [RULE_08] Request flag follows count every cycle, no software clearing.
`timescale 1ns/1ps
module spi_fifo_hold_and_request
#(
    parameter int RX_CNT_W = spi_stall_pkg::RX_CNT_W_DEFAULT,
    parameter int HALF_CYCLES = spi_stall_pkg::SCK_HALF_DEFAULT
)
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [spi_stall_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Transmit FIFO read side.
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_pop,
    // Receive FIFO fill level.
    input wire logic [RX_CNT_W-1:0] i_rx_count,
    // Serial line.
    output logic o_sck,
    output logic o_mosi,
    // Interrupt.
    output logic o_irq
);
    import spi_stall_pkg::*;

    typedef struct packed {
        xfer_state_type st;
        logic stall;
        logic irq_en;
        logic mask_rx;
        logic [RX_CNT_W-1:0] thresh;
        logic done_flag;
        logic rx_evt;
        logic rx_req;
        logic go_pend;
        logic start;
        logic [7:0] tx_byte;
        logic pop;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } ctl_state_type;

    ctl_state_type s_q;
    ctl_state_type s_d;

    shift_if bus ();

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_MASK)
            || (a == OFF_THRESH) || (a == OFF_XFER);
    endfunction : mapped

    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                              input ctl_state_type s);
        logic [31:0] w;
        w = '0;
        if (a == OFF_CTRL)
        begin
            w[CTRL_STALL_BIT] = s.stall;
            w[CTRL_IRQEN_BIT] = s.irq_en;
            w[CTRL_RXREQ_BIT] = s.rx_req;
        end
        else if (a == OFF_STATUS)
        begin
            w[INT_DONE_BIT] = s.done_flag;
            w[INT_RXREQ_BIT] = s.rx_evt;
        end
        else if (a == OFF_MASK)
        begin
            w[INT_DONE_BIT] = s.irq_en;
            w[INT_RXREQ_BIT] = s.mask_rx;
        end
        else if (a == OFF_THRESH)
        begin
            w = 32'(s.thresh);
        end
        else if (a == OFF_XFER)
        begin
            w[XFER_GO_BIT] = s.go_pend;
        end
        read_word = w;
    endfunction : read_word

    logic acc;
    logic wr;
    logic launch;
    logic from_fifo;

    always_comb
    begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.pop = 1'b0;
        s_d.pready = 1'b0;
        acc = i_psel && i_penable;
        // The answer comes one cycle into the access phase.
        if (acc && !s_q.pready)
        begin
            s_d.pready = 1'b1;
            s_d.pslverr = !mapped(i_paddr);
            s_d.prdata = i_pwrite ? 32'h00000000 : read_word(i_paddr, s_q);
        end
        wr = acc && s_q.pready && i_pwrite && mapped(i_paddr);
        launch = 1'b0;
        from_fifo = 1'b0;

        // The stall is only looked at when a byte is about to start.
        unique case (s_q.st)
            XF_IDLE:
            begin
                launch = s_q.go_pend || (i_tx_valid && !s_q.stall);
                from_fifo = !s_q.stall && i_tx_valid; // RULE_02
                if (launch)
                begin
                    s_d.start = 1'b1;
                    s_d.tx_byte = from_fifo ? i_tx_data : FILLER_BYTE; // RULE_02
                    s_d.pop = from_fifo; // RULE_03
                    s_d.go_pend = 1'b0;
                    s_d.st = XF_SHIFT;
                end
            end
            XF_SHIFT:
            begin
                if (bus.done)
                begin
                    s_d.st = XF_IDLE; // RULE_01
                end
            end
        endcase

        if (wr && i_paddr == OFF_CTRL)
        begin
            s_d.stall = i_pwdata[CTRL_STALL_BIT];
            s_d.irq_en = i_pwdata[CTRL_IRQEN_BIT]; // RULE_04
        end
        if (wr && i_paddr == OFF_MASK)
        begin
            s_d.irq_en = i_pwdata[INT_DONE_BIT];
            s_d.mask_rx = i_pwdata[INT_RXREQ_BIT];
        end
        if (wr && i_paddr == OFF_THRESH)
        begin
            s_d.thresh = i_pwdata[RX_CNT_W-1:0];
        end
        if (wr && i_paddr == OFF_XFER && i_pwdata[XFER_GO_BIT])
        begin
            s_d.go_pend = 1'b1;
        end

        // Sticky flags: a hardware set in the clearing cycle wins.
        if (wr && i_paddr == OFF_STATUS && i_pwdata[INT_DONE_BIT])
        begin
            s_d.done_flag = 1'b0;
        end
        if (wr && i_paddr == OFF_STATUS && i_pwdata[INT_RXREQ_BIT])
        begin
            s_d.rx_evt = 1'b0;
        end
        if (bus.done)
        begin
            s_d.done_flag = 1'b1;
        end

        s_d.rx_req = i_rx_count > s_q.thresh; // RULE_06 RULE_07 RULE_08
        if (s_d.rx_req && !s_q.rx_req)
        begin
            s_d.rx_evt = 1'b1;
        end

        // Registered from next state so the pin follows the flags at once.
        s_d.irq = (s_d.done_flag && s_d.irq_en) // RULE_04 RULE_05
            || (s_d.rx_evt && s_d.mask_rx);
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            s_q <= '0;
            s_q.stall <= STALL_RESET;
            s_q.irq_en <= IRQEN_RESET;
            s_q.mask_rx <= MASK_RX_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bus.start = s_q.start;
    assign bus.data = s_q.tx_byte;

    spi_byte_shifter #(
        .HALF_CYCLES(HALF_CYCLES)
    ) u_shifter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(bus)
    );

    assign o_pready = s_q.pready;
    assign o_prdata = s_q.prdata;
    assign o_pslverr = s_q.pslverr;
    assign o_tx_pop = s_q.pop;
    assign o_sck = bus.sck;
    assign o_mosi = bus.mosi;
    assign o_irq = s_q.irq;

    a_byte_completes: assert property ( // RULE_01
        @(posedge i_clk) disable iff (!i_rst_n)
        (s_q.st == XF_SHIFT && !bus.done) |=> s_q.st == XF_SHIFT
    ) else $error("Byte left before shifting finished.");

    a_stall_filler_sent: assert property ( // RULE_02
        @(posedge i_clk) disable iff (!i_rst_n)
        (s_q.st == XF_IDLE && s_q.stall && s_q.go_pend)
        |=> (s_q.start && s_q.tx_byte == FILLER_BYTE)
    ) else $error("Stalled transfer did not send the filler.");

    a_stall_no_pop: assert property ( // RULE_02
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.stall |=> !s_q.pop
    ) else $error("Transmit FIFO popped while stalled.");

    a_resume_from_fifo: assert property ( // RULE_03
        @(posedge i_clk) disable iff (!i_rst_n)
        (s_q.st == XF_IDLE && !s_q.stall && i_tx_valid)
        |=> (s_q.pop && s_q.start && s_q.tx_byte == $past(i_tx_data))
    ) else $error("Queued byte was not taken after stall cleared.");

    a_irq_on_done: assert property ( // RULE_04
        @(posedge i_clk) disable iff (!i_rst_n)
        (bus.done && s_q.irq_en && !wr) |=> (o_irq && s_q.done_flag)
    ) else $error("Enabled done flag gave no interrupt.");

    a_irq_disabled: assert property ( // RULE_05
        @(posedge i_clk) disable iff (!i_rst_n)
        (!s_q.irq_en && !(s_q.rx_evt && s_q.mask_rx)) |-> !o_irq
    ) else $error("Interrupt raised with enable at zero.");

    a_rxreq_above: assert property ( // RULE_06
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rx_count > s_q.thresh) |=> s_q.rx_req
    ) else $error("Request flag low with count above threshold.");

    a_rxreq_at_or_below: assert property ( // RULE_07
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rx_count <= s_q.thresh) |=> !s_q.rx_req
    ) else $error("Request flag high with count at threshold.");

    a_rxreq_tracks: assert property ( // RULE_08
        @(posedge i_clk) disable iff (!i_rst_n)
        $fell(s_q.rx_req) |-> $past(i_rx_count) <= $past(s_q.thresh)
    ) else $error("Request flag fell without the count dropping.");

    a_apb_ready_pulse: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.pready |=> !s_q.pready
    ) else $error("APB ready held for more than one cycle.");

    // A start while shifting would be ignored by the shifter and its byte lost.
    a_no_start_busy: assert property ( // RULE_01
        @(posedge i_clk) disable iff (!i_rst_n)
        (s_q.st == XF_SHIFT) |=> !s_q.start
    ) else $error("New byte started while one was shifting.");

    a_sck_idle_low: assert property ( // RULE_01
        @(posedge i_clk) disable iff (!i_rst_n)
        (s_q.st == XF_IDLE) |-> !o_sck
    ) else $error("Serial clock high between bytes.");

    a_filler_without_pop: assert property ( // RULE_02
        @(posedge i_clk) disable iff (!i_rst_n)
        (s_q.start && !s_q.pop) |-> (s_q.tx_byte == FILLER_BYTE)
    ) else $error("Byte sent without a pop was not the filler.");

    a_pop_single: assert property ( // RULE_03
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.pop |=> !s_q.pop
    ) else $error("Transmit FIFO popped twice for one byte.");

    a_done_sets_flag: assert property ( // RULE_04
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.done |=> s_q.done_flag
    ) else $error("Finished byte did not set the done flag.");

endmodule : spi_fifo_hold_and_request

/* bench/spi_peer.sv */
// Serial peer that captures bytes sent MSB first on the data line.
`timescale 1ns/1ps
module spi_peer
(
    // Serial line.
    input wire logic i_sck,
    input wire logic i_mosi,
    // Captured bytes.
    output logic [7:0] o_byte,
    output int o_count
);
    logic [7:0] sh_q;
    int bits_q;

    initial
    begin
        sh_q = 8'h00;
        bits_q = 0;
        o_byte = 8'h00;
        o_count = 0;
    end

    // Mode 0: data is sampled on the rising serial clock edge.
    always @(posedge i_sck)
    begin
        sh_q = {sh_q[6:0], i_mosi};
        bits_q = bits_q + 1;
        if (bits_q == 8)
        begin
            bits_q = 0;
            o_byte = sh_q;
            o_count = o_count + 1;
        end
    end
endmodule : spi_peer

/* bench/tb_spi_fifo_hold_and_request.sv */
// Testbench for the transmit stall, interrupt and receive request block.
`timescale 1ns/1ps
module tb_spi_fifo_hold_and_request;
    import spi_stall_pkg::*;
    localparam logic [31:0] EN = 32'h1 << CTRL_IRQEN_BIT;
    localparam logic [31:0] ST = 32'h1 << CTRL_STALL_BIT;
    localparam logic [31:0] RQ = 32'h1 << CTRL_RXREQ_BIT;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr, tx_data, rx_byte;
    logic [31:0] pwdata, prdata, rdat;
    logic tx_valid, tx_pop, sck, mosi, irq, fill;
    logic [3:0] rx_count;
    int num_errors, samples_checked, pops, rx_seen;

    // The bench plays a two-entry transmit FIFO popped by the block.
    assign tx_valid = fill && pops < 2;
    assign tx_data = (pops == 0) ? 8'hA5 : 8'h3C;

    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        if (tx_pop === 1'h1)
            pops <= pops + 1;
    end

    spi_fifo_hold_and_request #(.RX_CNT_W(4), .HALF_CYCLES(2)) DUT (
        .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .o_tx_pop(tx_pop), .i_rx_count(rx_count), .o_sck(sck),
        .o_mosi(mosi), .o_irq(irq));

    spi_peer peer (.i_sck(sck), .i_mosi(mosi), .o_byte(rx_byte),
        .o_count(rx_seen));

    task stop_test;
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; held until pready is sampled high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20)
        begin
            num_errors++;
            stop_test();
        end
        @(posedge clk);
    endtask : apb

    // Bounded wait on the pop count or on the captured byte count.
    task wait_n(input logic sel_pop, input int target);
        int n;
        n = 0;
        while ((sel_pop ? pops : rx_seen) < target && n < 300)
        begin
            n++;
            @(posedge clk);
        end
        if (n >= 300)
        begin
            num_errors++;
            stop_test();
        end
    endtask : wait_n

    task s_reset;
        apb(1'h0, OFF_CTRL, 32'h0);
        chk(rdat, EN);
        chk(rerr, 1'h0);
        apb(1'h0, OFF_THRESH, 32'h0);
        chk(rdat, 32'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk(rerr, 1'h1);
        chk(rdat, 32'h0);
        chk(irq, 1'h0);
    endtask : s_reset

    task s_stall;
        fill <= 1'h1;
        wait_n(1'h1, 1);
        apb(1'h1, OFF_CTRL, EN | ST);
        wait_n(1'h0, 1);
        chk(rx_byte, 8'hA5);
        repeat (40) @(posedge clk);
        chk(pops, 1);
        chk(irq, 1'h1);
        apb(1'h1, OFF_XFER, 32'h1);
        wait_n(1'h0, 2);
        chk(rx_byte, FILLER_BYTE);
        chk(pops, 1);
        apb(1'h1, OFF_CTRL, EN);
        wait_n(1'h0, 3);
        chk(rx_byte, 8'h3C);
        chk(pops, 2);
        repeat (10) @(posedge clk);
        apb(1'h1, OFF_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'h0);
    endtask : s_stall

    task s_irq_off;
        apb(1'h1, OFF_CTRL, 32'h0);
        apb(1'h1, OFF_XFER, 32'h1);
        wait_n(1'h0, 4);
        repeat (10) @(posedge clk);
        chk(irq, 1'h0);
        apb(1'h0, OFF_STATUS, 32'h0);
        chk(rdat, 32'h1);
        apb(1'h1, OFF_STATUS, 32'h1);
        apb(1'h1, OFF_CTRL, EN);
    endtask : s_irq_off

    task s_rxreq;
        apb(1'h1, OFF_THRESH, 32'h5);
        apb(1'h0, OFF_THRESH, 32'h0);
        chk(rdat, 32'h5);
        rx_count <= 4'h5;
        apb(1'h0, OFF_CTRL, 32'h0);
        chk(rdat, EN);
        rx_count <= 4'h6;
        apb(1'h0, OFF_CTRL, 32'h0);
        chk(rdat, EN | RQ);
        chk(irq, 1'h0);
        apb(1'h1, OFF_MASK, 32'h3);
        apb(1'h0, OFF_MASK, 32'h0);
        chk(rdat, 32'h3);
        rx_count <= 4'h5;
        apb(1'h0, OFF_CTRL, 32'h0);
        chk(rdat, EN);
        rx_count <= 4'h6;
        repeat (3) @(posedge clk);
        chk(irq, 1'h1);
        apb(1'h0, OFF_STATUS, 32'h0);
        chk(rdat, 32'h2);
        apb(1'h1, OFF_STATUS, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 1'h0);
    endtask : s_rxreq

    initial
    begin
        clk = 1'h0;
        rst_n = 1'h0;
        {psel, penable, pwrite, fill} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rx_count = 4'h0;
        pops = 0;
        num_errors = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        s_reset();
        s_stall();
        s_irq_off();
        s_rxreq();
        // A second reset must bring back the documented reset values.
        rx_count <= 4'h0;
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        s_reset();
        stop_test();
    end
endmodule : tb_spi_fifo_hold_and_request
